/* src/capture_compare_pwm_unit.sv */
// capture/compare/pwm unit: 16-bit capture and compare on the first timer, 10-bit pwm on the second
//
// Function
// R1 - mode 0000 disables the unit and clears its prescaler, duty latch, and compare and pwm latches.
// R2 - mode 0010 toggles the pin on each compare match and sets the flag.
// R3 - capture event: 0100 falling, 0101 rising, 0110 fourth rising, 0111 sixteenth rising.
// R4 - mode 1000 drives pin low on entry, high on match, sets flag.
// R5 - mode 1001 drives pin high on entry, low on match, sets flag.
// R6 - mode 1010 match only sets flag; pin follows its port latch.
// R7 - mode 1011 match sets flag, clears first timer, starts conversion if converter enabled.
// R8 - modes 11xx are pwm; duty is data low byte with control bits 5:4.
// R9 - data low, data high and control are separate readable and writable bytes; data high is not writable in pwm.
// R10 - first timer serves capture and compare, second timer serves pwm.
// R11 - a capture event copies the whole first timer into the data bytes.
// R12 - each capture sets the sticky flag; a new capture overwrites unread data.
// R13 - software avoids capture while the first timer counts asynchronously.
// R14 - prescaler clears when unit is off, capture left, or on reset.
// R15 - switching between capture prescalers keeps the prescaler count; early capture possible.
// R16 - software masks the interrupt while changing capture modes, then clears flag.
// R17 - capture watches the pin level, so port writes to an output pin may capture.
// R18 - compare checks data word against first timer every cycle; acts and flags together.
// R19 - software sets pin as output for pin-driving compare modes.
// R20 - writing zero to control forces the compare output latch low.
// R21 - software runs the first timer synchronously when comparing.
// R22 - duty low bits have no effect in capture or compare modes.
// R23 - pwm period end clears timer, sets pin unless duty zero, reloads duty; the unit drives no clear to the second timer.
// R24 - a compare match fires once per timer count, not while held equal.
module capture_compare_pwm_unit
	import capture_compare_pwm_unit_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic [15:0] first_timer_count,
	output logic first_timer_clear,
	input wire logic adc_enabled,
	output logic adc_start,
	input wire logic [7:0] second_timer_count,
	input wire logic [7:0] second_timer_period,
	input wire logic [1:0] second_timer_phase,
	input wire logic second_timer_tick,
	input wire logic unit_pin_in,
	output logic unit_pin_out,
	output logic unit_pin_oe,
	input wire logic pin_direction_bit,
	input wire logic shared_port_pin,
	output logic unit_irq_flag
);

	////////////////////////////////////////////////////////////////////////////////
	// state and decoded views of it

	unit_state_type q;
	unit_state_type d;
	logic [3:0] mode;
	logic is_capture;
	logic is_compare;
	logic is_pwm;
	logic pin_rise;
	logic pin_fall;
	logic cap_event;
	logic timer_equal;
	logic cmp_hit;
	logic period_hit;
	logic duty_end;
	logic [9:0] duty_next;
	logic [9:0] duty_cur;
	logic [15:0] unit_data_word;
	logic wr_ctrl;
	logic [3:0] new_mode;

	// mode grouping by the top two bits of unit_mode_select, with toggle mode 0010 also counted as compare
	assign mode = q.ctrl[MODE_MSB:MODE_LSB];
	assign is_capture = (mode[3:2] == GROUP_CAPTURE);
	assign is_compare = (mode == MODE_CMP_TOGGLE) || (mode[3:2] == GROUP_COMPARE);
	// R8 pwm mode decode
	assign is_pwm = (mode[3:2] == GROUP_PWM);
	assign unit_data_word = {q.data_hi, q.data_lo};
	assign wr_ctrl = reg_wr && (reg_addr == ADDR_UNIT_CONTROL);
	assign new_mode = reg_wdata[MODE_MSB:MODE_LSB];

	// R17 edges seen on the resolved pin level, whichever side drives it
	assign pin_rise = q.pin_s2 && !q.pin_prev;
	assign pin_fall = !q.pin_s2 && q.pin_prev;

	// R3 capture event selection
	always_comb begin
		case (mode)
			MODE_CAP_FALL: cap_event = pin_fall;
			MODE_CAP_RISE: cap_event = pin_rise;
			MODE_CAP_RISE4: cap_event = pin_rise && (q.psc == PSC_RISE4_LAST);
			MODE_CAP_RISE16: cap_event = pin_rise && (q.psc == PSC_RISE16_LAST);
			default: cap_event = 1'b0;
		endcase
	end

	// R18 compare every cycle against the first timer
	assign timer_equal = (unit_data_word == first_timer_count);
	// R24 one hit per count; a held equal value does not refire
	assign cmp_hit = is_compare && timer_equal && !(q.last_match && (first_timer_count == q.last_timer));

	// R10 pwm runs on the second timer
	assign period_hit = is_pwm && second_timer_tick && (second_timer_count == second_timer_period);
	// R8 ten-bit duty from data low byte and control bits 5:4
	assign duty_next = {q.data_lo, q.ctrl[DUTY_MSB:DUTY_LSB]};
	assign duty_cur = {q.data_hi, q.duty_latch};
	assign duty_end = is_pwm && (duty_cur == {second_timer_count, second_timer_phase});

	////////////////////////////////////////////////////////////////////////////////
	// next-state logic; hardware events come after software writes so that a set beats a clear, except the zero control write, which comes last

	always_comb begin
		d = q;
		// pin synchroniser: first stage feeds only the second
		d.pin_s1 = unit_pin_in;
		d.pin_s2 = q.pin_s1;
		d.pin_prev = q.pin_s2;
		d.last_timer = first_timer_count;
		d.last_match = timer_equal;
		d.rdata = DATA_RESET;
		d.timer_clear = 1'b0;
		d.adc_go = 1'b0;

		// R1 disabled unit holds its internals cleared
		if (mode == MODE_DISABLED) begin
			d.psc = PSC_CLEAR;
			d.cmp_out = 1'b0;
			d.pwm_out = 1'b0;
			d.duty_latch = 2'h0;
		end

		// R14 prescaler cleared outside capture modes
		if (!is_capture) begin
			d.psc = PSC_CLEAR;
		end else if (pin_rise) begin
			// R15 no clear when hopping between capture modes
			if ((mode == MODE_CAP_RISE4) && (q.psc == PSC_RISE4_LAST)) begin
				d.psc = PSC_CLEAR;
			end else begin
				d.psc = q.psc + PSC_STEP;
			end
		end

		// R9 software writes to the three bytes and the status
		if (reg_wr) begin
			if (reg_addr == ADDR_UNIT_CONTROL) begin
				d.ctrl = reg_wdata[CTRL_W-1:0];
				// R4 entering set-high mode starts the pin low
				if ((new_mode == MODE_CMP_SET_HIGH) && (new_mode != mode)) begin
					d.cmp_out = 1'b0;
				end
				// R5 entering set-low mode starts the pin high
				if ((new_mode == MODE_CMP_SET_LOW) && (new_mode != mode)) begin
					d.cmp_out = 1'b1;
				end
			end else if (reg_addr == ADDR_UNIT_DATA_LOW) begin
				d.data_lo = reg_wdata;
			end else if (reg_addr == ADDR_UNIT_DATA_HIGH) begin
				// high byte is the duty buffer in pwm and not writable there
				if (!is_pwm) begin
					d.data_hi = reg_wdata;
				end
			end else if (reg_addr == ADDR_UNIT_STATUS) begin
				if (reg_wdata[STATUS_FLAG_BIT]) begin
					d.flag = 1'b0;
				end
			end
		end

		// R9 read data in the following cycle
		if (reg_rd) begin
			if (reg_addr == ADDR_UNIT_CONTROL) begin
				d.rdata = {2'h0, q.ctrl};
			end else if (reg_addr == ADDR_UNIT_DATA_LOW) begin
				d.rdata = q.data_lo;
			end else if (reg_addr == ADDR_UNIT_DATA_HIGH) begin
				d.rdata = q.data_hi;
			end else begin
				d.rdata = {7'h00, q.flag};
			end
		end

		// R11 capture copies the full timer, overwriting unread data
		if (cap_event) begin
			d.data_hi = first_timer_count[15:8];
			d.data_lo = first_timer_count[7:0];
			// R12 sticky flag on capture
			d.flag = 1'b1;
		end

		// R18 pin action and flag on the same match
		if (cmp_hit) begin
			d.flag = 1'b1;
			case (mode)
				// R2 toggle on match
				MODE_CMP_TOGGLE: d.cmp_out = !q.cmp_out;
				// R4 force high on match
				MODE_CMP_SET_HIGH: d.cmp_out = 1'b1;
				// R5 force low on match
				MODE_CMP_SET_LOW: d.cmp_out = 1'b0;
				// R7 special trigger pulse
				MODE_CMP_TRIGGER: begin
					d.timer_clear = 1'b1;
					d.adc_go = adc_enabled;
				end
				// R6 flag only, pin untouched
				default: d.cmp_out = q.cmp_out;
			endcase
		end

		// R20 a zero control write forces the latch low, even over a match in the same cycle
		if (wr_ctrl && (reg_wdata == CTRL_CLEAR_VALUE)) begin
			d.cmp_out = 1'b0;
		end

		// R23 period end reloads the duty buffer and raises the pin unless the new duty is zero
		if (period_hit) begin
			d.pwm_out = (duty_next != DUTY_ZERO);
			d.data_hi = q.data_lo;
			// R22 duty bits reach the logic only here, in pwm
			d.duty_latch = q.ctrl[DUTY_MSB:DUTY_LSB];
		end else if (duty_end) begin
			// duty longer than the period never clears the pin
			d.pwm_out = 1'b0;
		end

		// pin source: pwm, driving compare latch, or the port latch
		if (is_pwm) begin
			d.pin_out = q.pwm_out;
		end else if ((mode == MODE_CMP_TOGGLE) || (mode == MODE_CMP_SET_HIGH) || (mode == MODE_CMP_SET_LOW)) begin
			d.pin_out = q.cmp_out;
		end else begin
			// R6 port latch owns the pin in soft-interrupt and other modes
			d.pin_out = shared_port_pin;
		end
		// direction bit high means input, so drive only when it is low
		d.pin_oe = !pin_direction_bit;
	end

	////////////////////////////////////////////////////////////////////////////////
	// state register with synchronous reset

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			q <= STATE_RESET;
		end else begin
			q <= d;
		end
	end

	// outputs straight from flip-flops
	assign reg_rdata = q.rdata;
	assign unit_irq_flag = q.flag;
	assign unit_pin_out = q.pin_out;
	assign unit_pin_oe = q.pin_oe;
	assign first_timer_clear = q.timer_clear;
	assign adc_start = q.adc_go;

	////////////////////////////////////////////////////////////////////////////////
	// checks on the unit's own behaviour

	sequence s_one_pulse;
		first_timer_clear ##1 !first_timer_clear;
	endsequence

	sequence s_quiet_write;
		!reg_wr;
	endsequence

	property p_disabled_clears;
		@(posedge clk) disable iff (!rst_b)
		(mode == MODE_DISABLED) ##1 (mode == MODE_DISABLED) |-> (q.psc == PSC_CLEAR) && !q.cmp_out && !q.pwm_out;
	endproperty
	a_disabled_clears: assert property (p_disabled_clears) else $error("disabled unit kept state"); // R1

	property p_toggle;
		@(posedge clk) disable iff (!rst_b)
		(mode == MODE_CMP_TOGGLE) && cmp_hit and s_quiet_write |=> (q.cmp_out != $past(q.cmp_out)) && q.flag;
	endproperty
	a_toggle: assert property (p_toggle) else $error("toggle match did not invert latch"); // R2

	property p_rise16_gate;
		@(posedge clk) disable iff (!rst_b)
		(mode == MODE_CAP_RISE16) && (q.psc != PSC_RISE16_LAST) |-> !cap_event;
	endproperty
	a_rise16_gate: assert property (p_rise16_gate) else $error("capture before sixteenth edge"); // R3

	property p_set_high;
		@(posedge clk) disable iff (!rst_b)
		(mode == MODE_CMP_SET_HIGH) && cmp_hit and s_quiet_write |=> q.cmp_out ##1 (unit_pin_out == q.cmp_out);
	endproperty
	a_set_high: assert property (p_set_high) else $error("set-high match failed"); // R4

	property p_set_low;
		@(posedge clk) disable iff (!rst_b)
		(mode == MODE_CMP_SET_LOW) && cmp_hit and s_quiet_write |=> !q.cmp_out && q.flag;
	endproperty
	a_set_low: assert property (p_set_low) else $error("set-low match failed"); // R5

	property p_trigger;
		@(posedge clk) disable iff (!rst_b)
		(mode == MODE_CMP_TRIGGER) && cmp_hit |=> s_one_pulse and (adc_start == $past(adc_enabled));
	endproperty
	a_trigger: assert property (p_trigger) else $error("special trigger pulse wrong"); // R7

	property p_capture_copy;
		@(posedge clk) disable iff (!rst_b)
		cap_event |=> ({q.data_hi, q.data_lo} == $past(first_timer_count)) && q.flag;
	endproperty
	a_capture_copy: assert property (p_capture_copy) else $error("capture lost timer value"); // R11

	property p_flag_sticky;
		@(posedge clk) disable iff (!rst_b)
		q.flag && !(reg_wr && (reg_addr == ADDR_UNIT_STATUS)) |=> q.flag;
	endproperty
	a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped without clear"); // R12

	property p_psc_cleared;
		@(posedge clk) disable iff (!rst_b)
		!is_capture |=> (q.psc == PSC_CLEAR);
	endproperty
	a_psc_cleared: assert property (p_psc_cleared) else $error("prescaler kept outside capture"); // R14

	property p_zero_ctrl;
		@(posedge clk) disable iff (!rst_b)
		wr_ctrl && (reg_wdata == CTRL_CLEAR_VALUE) |=> !q.cmp_out [*2];
	endproperty
	a_zero_ctrl: assert property (p_zero_ctrl) else $error("zero control left latch high"); // R20

	property p_read_low;
		@(posedge clk) disable iff (!rst_b)
		reg_rd && (reg_addr == ADDR_UNIT_DATA_LOW) |=> (reg_rdata == $past(q.data_lo))
			##1 ((reg_rdata == DATA_RESET) || $past(reg_rd));
	endproperty
	a_read_low: assert property (p_read_low) else $error("data low read wrong"); // R9

	property p_no_refire;
		@(posedge clk) disable iff (!rst_b)
		cmp_hit ##1 ($stable(first_timer_count) && $stable(unit_data_word) && $stable(mode)) |-> !cmp_hit;
	endproperty
	a_no_refire: assert property (p_no_refire) else $error("match refired on held count"); // R24

	property p_period_reload;
		@(posedge clk) disable iff (!rst_b)
		period_hit |=> (q.data_hi == $past(q.data_lo)) && (q.pwm_out == ($past(duty_next) != DUTY_ZERO));
	endproperty
	a_period_reload: assert property (p_period_reload) else $error("pwm period end wrong"); // R23

endmodule : capture_compare_pwm_unit

/* src/capture_compare_pwm_unit_pkg.sv */
// constants, register map and state layout of the capture/compare/pwm unit
package capture_compare_pwm_unit_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// timing and widths
	localparam int CLK_PERIOD_NS = 50;
	localparam int REG_ADDR_W = 2;
	localparam int REG_DATA_W = 8;
	localparam int FIRST_TIMER_W = 16;
	localparam int SECOND_TIMER_W = 8;
	localparam int CTRL_W = 6;
	localparam int PSC_W = 4;

	////////////////////////////////////////////////////////////////////////////////
	// register offsets
	localparam logic [1:0] ADDR_UNIT_CONTROL = 2'h0;
	localparam logic [1:0] ADDR_UNIT_DATA_LOW = 2'h1;
	localparam logic [1:0] ADDR_UNIT_DATA_HIGH = 2'h2;
	localparam logic [1:0] ADDR_UNIT_STATUS = 2'h3;

	// control field positions
	localparam int MODE_LSB = 0;
	localparam int MODE_MSB = 3;
	localparam int DUTY_LSB = 4;
	localparam int DUTY_MSB = 5;
	localparam int STATUS_FLAG_BIT = 0;

	// reset values
	localparam logic [5:0] CTRL_RESET = 6'h00;
	localparam logic [7:0] DATA_RESET = 8'h00;
	localparam logic [7:0] CTRL_CLEAR_VALUE = 8'h00;

	////////////////////////////////////////////////////////////////////////////////
	// mode codes of unit_mode_select
	localparam logic [3:0] MODE_DISABLED = 4'h0;
	localparam logic [3:0] MODE_CMP_TOGGLE = 4'h2;
	localparam logic [3:0] MODE_CAP_FALL = 4'h4;
	localparam logic [3:0] MODE_CAP_RISE = 4'h5;
	localparam logic [3:0] MODE_CAP_RISE4 = 4'h6;
	localparam logic [3:0] MODE_CAP_RISE16 = 4'h7;
	localparam logic [3:0] MODE_CMP_SET_HIGH = 4'h8;
	localparam logic [3:0] MODE_CMP_SET_LOW = 4'h9;
	localparam logic [3:0] MODE_CMP_SOFT_IRQ = 4'ha;
	localparam logic [3:0] MODE_CMP_TRIGGER = 4'hb;
	localparam logic [1:0] GROUP_CAPTURE = 2'h1;
	localparam logic [1:0] GROUP_COMPARE = 2'h2;
	localparam logic [1:0] GROUP_PWM = 2'h3;

	// last prescaler count before a divided capture
	localparam logic [3:0] PSC_RISE4_LAST = 4'h3;
	localparam logic [3:0] PSC_RISE16_LAST = 4'hf;
	localparam logic [3:0] PSC_CLEAR = 4'h0;
	localparam logic [3:0] PSC_STEP = 4'h1;
	localparam logic [9:0] DUTY_ZERO = 10'h000;

	////////////////////////////////////////////////////////////////////////////////
	// whole state of the unit
	typedef struct packed {
		logic [5:0] ctrl;
		logic [7:0] data_lo;
		logic [7:0] data_hi;
		logic [1:0] duty_latch;
		logic [3:0] psc;
		logic pin_s1;
		logic pin_s2;
		logic pin_prev;
		logic cmp_out;
		logic pwm_out;
		logic [15:0] last_timer;
		logic last_match;
		logic flag;
		logic [7:0] rdata;
		logic pin_out;
		logic pin_oe;
		logic timer_clear;
		logic adc_go;
	} unit_state_type;

	localparam unit_state_type STATE_RESET = '0;

endpackage : capture_compare_pwm_unit_pkg

/* tb/capture_compare_pwm_unit_test.sv */
// self-checking bench of the capture/compare/pwm unit
module capture_compare_pwm_unit_test import capture_compare_pwm_unit_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic [1:0] reg_addr = 2'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	// timer moves only with the core clock
	logic [15:0] first_timer_count = 16'h0000;
	logic first_timer_clear, adc_start, unit_pin_in, unit_pin_out, unit_pin_oe, unit_irq_flag;
	logic adc_enabled = 1'b0;
	logic [7:0] second_timer_count = 8'h00;
	logic [7:0] second_timer_period = 8'h00;
	logic [1:0] second_timer_phase = 2'h0;
	logic second_timer_tick = 1'b0;
	logic pin_direction_bit = 1'b1;
	logic shared_port_pin = 1'b0;
	logic ext_level = 1'b0;
	logic [3:0] lag = 4'h0;
	logic [15:0] v, w;
	int errors = 0;
	int total_checks = 0;
	int clears = 0;
	int starts = 0;

	capture_compare_pwm_unit i_dut (.clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.first_timer_count, .first_timer_clear, .adc_enabled, .adc_start, .second_timer_count,
		.second_timer_period, .second_timer_phase, .second_timer_tick, .unit_pin_in, .unit_pin_out,
		.unit_pin_oe, .pin_direction_bit, .shared_port_pin, .unit_irq_flag);
	pin_source_model i_pin (.clk, .level_req(ext_level), .lag, .unit_pin_out, .unit_pin_oe, .unit_pin_in);

	// core clock
	always #(CLK_PERIOD_NS / 2) clk = ~clk;
	// count trigger pulses; each is one cycle long
	always @(posedge clk) begin
		if (first_timer_clear === 1'b1) clears++;
		if (adc_start === 1'b1) starts++;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("unexpected %s: expected %h, seen %h", name, exp, got);
		end
	endtask : chk

	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr

	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [1:0] a, input logic [7:0] exp, input string name);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		chk(name, {8'h00, exp}, {8'h00, reg_rdata});
	endtask : rd

	// wait long enough for the source's lag plus the pin synchroniser
	task automatic level(input logic l);
		@(posedge clk);
		ext_level <= l;
		repeat (int'(lag) + 5) @(posedge clk);
		#1;
	endtask : level

	task automatic pulse();
		level(1'b1);
		level(1'b0);
	endtask : pulse

	task automatic presc(input logic [7:0] m, input int n);
		wr(2'h0, m);
		wr(2'h3, 8'h01);
		repeat (n - 1) pulse();
		chk("flag early", 16'h0, 16'(unit_irq_flag));
		level(1'b1);
		chk("flag", 16'h1, 16'(unit_irq_flag));
		level(1'b0);
	endtask : presc

	task automatic cmp(input logic [7:0] m, input logic init, input logic after);
		@(posedge clk);
		first_timer_count <= v ^ 16'h8000;
		wr(2'h0, m);
		wr(2'h3, 8'h01);
		repeat (3) @(posedge clk);
		#1;
		chk("pin at entry", 16'(init), 16'(unit_pin_out));
		chk("pin enable", 16'h1, 16'(unit_pin_oe));
		@(posedge clk);
		first_timer_count <= v;
		repeat (8) @(posedge clk);
		#1;
		chk("pin after match", 16'(after), 16'(unit_pin_out));
		chk("flag", 16'h1, 16'(unit_irq_flag));
	endtask : cmp

	task automatic period_tick();
		@(posedge clk);
		second_timer_tick <= 1'b1;
		@(posedge clk);
		second_timer_tick <= 1'b0;
		repeat (3) @(posedge clk);
		#1;
	endtask : period_tick

	task automatic finish_test();
		$display("checks %0d, errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : finish_test

	////////////////////////////////////////////////////////////////////////////////
	// watchdog, far beyond the some 1200 cycles at most the sequence needs
	initial begin
		repeat (40000) @(posedge clk);
		errors++;
		finish_test();
	end

	// main sequence
	initial begin
		void'($urandom(69135));
		repeat (12) @(posedge clk);
		rst_b <= 1'b1;
		lag <= 4'($urandom_range(0, 5));
		rd(2'h0, 8'h00, "control");
		rd(2'h1, 8'h00, "data_low");
		rd(2'h2, 8'h00, "data_high");
		chk("pin enable", 16'h0, 16'(unit_pin_oe));
		repeat (4) begin
			v = 16'($urandom);
			wr(2'h0, v[7:0] & 8'hf0);
			wr(2'h1, v[7:0]);
			wr(2'h2, v[15:8]);
			rd(2'h0, {2'b00, v[5:4], 4'h0}, "control");
			rd(2'h1, v[7:0], "data_low");
			rd(2'h2, v[15:8], "data_high");
		end
		wr(2'h0, 8'h05);
		wr(2'h3, 8'h01);
		// second capture overwrites the first
		repeat (2) begin
			v = 16'($urandom);
			@(posedge clk);
			first_timer_count <= v;
			pulse();
			chk("flag", 16'h1, 16'(unit_irq_flag));
			rd(2'h1, v[7:0], "captured low");
			rd(2'h2, v[15:8], "captured high");
		end
		wr(2'h0, 8'h04);
		wr(2'h3, 8'h01);
		level(1'b1);
		chk("flag on rise", 16'h0, 16'(unit_irq_flag));
		level(1'b0);
		chk("flag on fall", 16'h1, 16'(unit_irq_flag));
		rd(2'h3, 8'h01, "status");
		wr(2'h0, 8'h06);
		repeat (2) pulse();
		wr(2'h0, 8'h00);
		presc(8'h06, 4);
		presc(8'h07, 16);
		wr(2'h0, 8'h06);
		repeat (2) pulse();
		presc(8'h07, 14);
		@(posedge clk);
		pin_direction_bit <= 1'b0;
		wr(2'h0, 8'h00);
		v = 16'($urandom);
		wr(2'h1, v[7:0]);
		wr(2'h2, v[15:8]);
		cmp(8'h08, 1'b0, 1'b1);
		cmp(8'h09, 1'b1, 1'b0);
		wr(2'h0, 8'h00);
		cmp(8'h02, 1'b0, 1'b1);
		cmp(8'h02, 1'b1, 1'b0);
		@(posedge clk);
		shared_port_pin <= 1'b1;
		cmp(8'h0a, 1'b1, 1'b1);
		cmp(8'h38, 1'b0, 1'b1);
		@(posedge clk);
		shared_port_pin <= 1'b0;
		adc_enabled <= 1'b1;
		clears = 0;
		starts = 0;
		cmp(8'h0b, 1'b0, 1'b0);
		@(posedge clk);
		adc_enabled <= 1'b0;
		cmp(8'h0b, 1'b0, 1'b0);
		chk("timer clears", 16'h2, 16'(clears));
		chk("conversion starts", 16'h1, 16'(starts));
		// duty high byte chosen apart from the timer count so no early clear
		w = 16'($urandom_range(33, 255));
		@(posedge clk);
		second_timer_count <= 8'h20;
		second_timer_period <= 8'h20;
		wr(2'h0, 8'h3c);
		wr(2'h1, w[7:0]);
		wr(2'h2, 8'h5a);
		rd(2'h2, v[15:8], "data_high in pwm");
		period_tick();
		chk("pin at period", 16'h1, 16'(unit_pin_out));
		rd(2'h2, w[7:0], "data_high");
		@(posedge clk);
		second_timer_count <= w[7:0];
		second_timer_phase <= 2'h3;
		repeat (3) @(posedge clk);
		#1;
		chk("pin at duty", 16'h0, 16'(unit_pin_out));
		@(posedge clk);
		second_timer_count <= 8'h20;
		period_tick();
		chk("pin at next period", 16'h1, 16'(unit_pin_out));
		wr(2'h1, 8'h00);
		wr(2'h0, 8'h0c);
		period_tick();
		chk("pin at zero duty", 16'h0, 16'(unit_pin_out));
		rd(2'h2, 8'h00, "data_high");
		finish_test();
	end
endmodule : capture_compare_pwm_unit_test

/* tb/pin_source_model.sv */
// far-side signal source driving the unit's shared pin
module pin_source_model (
	input wire logic clk,
	input wire logic level_req,
	input wire logic [3:0] lag,
	input wire logic unit_pin_out,
	input wire logic unit_pin_oe,
	output logic unit_pin_in
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] hist_q = 16'h0000;
	// delay line so the source can answer promptly or slowly
	always @(posedge clk) begin
		hist_q <= {hist_q[14:0], level_req};
	end
	assign unit_pin_in = unit_pin_oe ? unit_pin_out : hist_q[lag];
endmodule : pin_source_model
